// ### logic/msp_supervisor.sv
/*
  supervision logic of a remote analog i/o module: engineering-unit
  encoding, command indicator, initialisation mode, dual watchdog,
  safe outputs and reset-status flag.
  assumes a host-command parser upstream delivering decoded commands and a
  response transmitter reporting end of reply; all inputs synchronous.
*/
`timescale 1ns/10ps

module msp_supervisor
#(
  parameter int HWD_STEP = msp_pkg::HWD_STEP_CYCLES,
  parameter int MWD_LIMIT = msp_pkg::MWD_CYCLES
)
(
  input  wire logic                    i_mclk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_clk_en,
  input  wire logic                    i_init_strap,
  input  wire msp_pkg::msp_cmd_req_t   i_cmd,
  input  wire logic                    i_resp_done,
  input  wire logic                    i_status_sent,
  input  wire logic                    i_mb_status_read,
  input  wire logic                    i_kick,
  input  wire msp_pkg::msp_cfg_t       i_stored_cfg,
  input  wire logic [7:0]              i_hwd_timeout,
  input  wire logic [7:0]              i_rd_type,
  input  wire logic signed [15:0]      i_rd_raw,
  input  wire logic                    i_rd_valid,
  input  wire logic [msp_pkg::MSP_DO_W-1:0] i_do_cmd,
  input  wire logic                    i_do_wr,
  input  wire logic [msp_pkg::MSP_DO_W-1:0] i_do_safe,
  input  wire logic [msp_pkg::MSP_DO_W-1:0] i_do_pwron,
  input  wire logic                    i_pwron_use_safe,
  output logic                         o_pwr_led,
  output msp_pkg::msp_cfg_t            o_work_cfg,
  output logic                         o_init_mode,
  output logic                         o_cfg_wr,
  output msp_pkg::msp_cfg_t            o_cfg_wr_data,
  output logic                         o_readback_stored,
  output logic                         o_type_wr,
  output logic [2:0]                   o_type_chan,
  output logic [7:0]                   o_type_val,
  output logic                         o_cal_reload,
  output logic                         o_reset_status,
  output logic                         o_hwd_expired,
  output logic                         o_mod_reset,
  output logic signed [15:0]           o_eu_value,
  output logic                         o_eu_valid,
  output logic [msp_pkg::MSP_DO_W-1:0] o_dout
);
  import msp_pkg::*;

  // ************************************************************
  // init strap capture
  // ************************************************************
  logic strap_taken_r;
  logic init_mode_r;
  msp_cfg_t work_cfg_r;

  // strap is caught once after reset release; later changes are ignored
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      strap_taken_r <= 1'b0;
      init_mode_r   <= 1'b0;
    end
    else if (i_clk_en && !strap_taken_r)
    begin
      strap_taken_r <= 1'b1;
      init_mode_r   <= i_init_strap;
    end
  end

  // working settings: defaults in init mode, stored otherwise
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      work_cfg_r <= '{addr: MSP_INIT_ADDR, baud: MSP_BAUD_9600, cks_en: MSP_INIT_CKS, proto_mb: MSP_PROTO_ASCII};
    else if (i_clk_en && !strap_taken_r)
    begin
      if (i_init_strap)
        work_cfg_r <= '{addr: MSP_INIT_ADDR, baud: MSP_BAUD_9600, cks_en: MSP_INIT_CKS,
                        proto_mb: MSP_PROTO_ASCII};
      else
        work_cfg_r <= i_stored_cfg;
    end
  end

  // ************************************************************
  // command handling
  // ************************************************************
  // config writes are built on the stored copy, not the working one, so the stored copy is never
  // touched by the default settings themselves
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_cfg_wr          <= 1'b0;
      o_cfg_wr_data     <= '0;
      o_readback_stored <= 1'b0;
      o_type_wr         <= 1'b0;
      o_type_chan       <= '0;
      o_type_val        <= '0;
      o_cal_reload      <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_cfg_wr          <= 1'b0;
      o_readback_stored <= 1'b0;
      o_type_wr         <= 1'b0;
      o_cal_reload      <= 1'b0;
      if (i_cmd.valid)
      begin
        case (i_cmd.cmd)
          MSP_CMD_SET_CONFIG:
          begin
            o_cfg_wr      <= 1'b1;
            o_cfg_wr_data <= i_stored_cfg;
            o_cfg_wr_data.addr <= i_cmd.arg_type;
            if (init_mode_r)
            begin
              o_cfg_wr_data.baud   <= i_cmd.arg_baud;
              o_cfg_wr_data.cks_en <= i_cmd.arg_cks;
            end
          end
          MSP_CMD_PROTO_SELECT:
          begin
            if (init_mode_r)
            begin
              o_cfg_wr               <= 1'b1;
              o_cfg_wr_data          <= i_stored_cfg;
              o_cfg_wr_data.proto_mb <= i_cmd.arg_proto;
            end
          end
          MSP_CMD_CFG_READBACK:
            o_readback_stored <= 1'b1;
          MSP_CMD_SET_TYPE:
          begin
            o_type_wr   <= 1'b1;
            o_type_chan <= i_cmd.chan;
            o_type_val  <= i_cmd.arg_type;
          end
          MSP_CMD_MB_VENDOR:
          begin
            if (i_cmd.func_code == MSP_MB_VENDOR_FC && i_cmd.sub_func == MSP_MB_SUB_TYPE)
            begin
              o_type_wr   <= 1'b1;
              o_type_chan <= i_cmd.chan;
              o_type_val  <= i_cmd.arg_type;
            end
          end
          MSP_CMD_FACTORY_CAL:
            o_cal_reload <= 1'b1;
          default:
            o_cal_reload <= 1'b0;
        endcase
      end
    end
  end

  // ************************************************************
  // power indicator
  // ************************************************************
  // off from command to end of reply, so the host can see reception
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_pwr_led <= 1'b1;
    else if (i_clk_en)
    begin
      if (i_cmd.valid)
        o_pwr_led <= 1'b0;
      else if (i_resp_done)
        o_pwr_led <= 1'b1;
    end
  end

  // ************************************************************
  // host watchdog
  // ************************************************************
  logic [31:0] hwd_tick_r;
  logic [7:0]  hwd_units_r;
  logic        hwd_exp_r;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      hwd_tick_r  <= '0;
      hwd_units_r <= '0;
      hwd_exp_r   <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (i_cmd.valid || i_hwd_timeout == 8'h00)
      begin
        hwd_tick_r  <= '0;
        hwd_units_r <= '0;
        hwd_exp_r   <= 1'b0;
      end
      else if (!hwd_exp_r)
      begin
        if (hwd_tick_r == 32'(HWD_STEP - 1))
        begin
          hwd_tick_r  <= '0;
          hwd_units_r <= hwd_units_r + 8'h01;
          if (hwd_units_r + 8'h01 == i_hwd_timeout)
            hwd_exp_r <= 1'b1;
        end
        else
          hwd_tick_r <= hwd_tick_r + 32'h1;
      end
    end
  end

  // ************************************************************
  // module watchdog
  // ************************************************************
  // runs even with clock enable low: a frozen core is exactly the stall it hunts
  logic [31:0] mwd_cnt_r;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mwd_cnt_r   <= '0;
      o_mod_reset <= 1'b0;
    end
    else if (i_kick || o_mod_reset)
    begin
      mwd_cnt_r   <= '0;
      o_mod_reset <= 1'b0;
    end
    else if (mwd_cnt_r == 32'(MWD_LIMIT - 1))
      o_mod_reset <= 1'b1;
    else
      mwd_cnt_r <= mwd_cnt_r + 32'h1;
  end

  // ************************************************************
  // reset status flag
  // ************************************************************
  // set wins over clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_reset_status <= 1'b1;
    else if (o_mod_reset)
      o_reset_status <= 1'b1;
    else if (i_clk_en && (i_status_sent || i_mb_status_read))
      o_reset_status <= 1'b0;
  end

  // ************************************************************
  // digital outputs
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_dout <= '0;
    else if (o_mod_reset || !strap_taken_r)
      o_dout <= i_pwron_use_safe ? i_do_safe : i_do_pwron;
    else if (i_clk_en)
    begin
      if (hwd_exp_r)
        o_dout <= i_do_safe;
      else if (i_do_wr)
        o_dout <= i_do_cmd;
    end
  end

  // ************************************************************
  // engineering-unit encoding
  // ************************************************************
  logic signed [15:0] eu_nxt;

  // raw reading is already in units; it is clipped to sentinels by the table range
  always_comb
  begin
    eu_nxt = i_rd_raw;
    for (int k = 0; k < MSP_NUM_TYPES; k++)
    begin
      if (i_rd_type == MSP_TC[k])
      begin
        if (i_rd_raw < MSP_FS_LO[k])
          eu_nxt = MSP_UNDER;
        else if (i_rd_raw > MSP_FS_HI[k])
          eu_nxt = MSP_OVER;
        else
          eu_nxt = i_rd_raw;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_eu_value <= '0;
      o_eu_valid <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_eu_valid <= i_rd_valid;
      if (i_rd_valid)
        o_eu_value <= eu_nxt;
    end
  end

  // ************************************************************
  // status outputs
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_init_mode   <= 1'b0;
      o_work_cfg    <= '0;
      o_hwd_expired <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_init_mode   <= init_mode_r;
      o_work_cfg    <= work_cfg_r;
      o_hwd_expired <= hwd_exp_r;
    end
  end

endmodule

// ### logic/msp_pkg.sv
/*
  package for the module supervision and protocol block: command codes,
  type codes, engineering-unit limits, watchdog timing and default settings.
  assumes a single 100 MHz module clock.
*/
package msp_pkg;

  // ************************************************************
  // command codes decoded from the host parser
  // ************************************************************
  typedef enum logic [3:0]
  {
    MSP_CMD_NONE          = 4'b0000,
    MSP_CMD_RESET_STATUS  = 4'b0001,
    MSP_CMD_CFG_READBACK  = 4'b0010,
    MSP_CMD_SET_CONFIG    = 4'b0011,
    MSP_CMD_PROTO_SELECT  = 4'b0100,
    MSP_CMD_FACTORY_CAL   = 4'b0101,
    MSP_CMD_SET_TYPE      = 4'b0110,
    MSP_CMD_MB_VENDOR     = 4'b0111,
    MSP_CMD_OTHER         = 4'b1000
  } msp_cmd_t;

  // ************************************************************
  // command carrier from the parser
  // ************************************************************
  typedef struct packed
  {
    logic        valid;      // one-cycle strobe, command for this module
    msp_cmd_t    cmd;
    logic [7:0]  sub_func;   // modbus sub-function
    logic [7:0]  func_code;  // modbus function code
    logic [2:0]  chan;
    logic [7:0]  arg_type;   // type code argument
    logic [5:0]  arg_baud;
    logic        arg_cks;
    logic        arg_proto;  // 0 ascii, 1 modbus
  } msp_cmd_req_t;

  // working configuration
  typedef struct packed
  {
    logic [7:0] addr;
    logic [5:0] baud;
    logic       cks_en;
    logic       proto_mb;
  } msp_cfg_t;

  // ************************************************************
  // defaults used in initialisation mode
  // ************************************************************
  localparam logic [7:0] MSP_INIT_ADDR  = 8'h00;
  localparam logic [5:0] MSP_BAUD_9600  = 6'h0A;
  localparam logic       MSP_INIT_CKS   = 1'b0;
  localparam logic       MSP_PROTO_ASCII = 1'b0;

  // modbus vendor function and type sub-function
  localparam logic [7:0] MSP_MB_VENDOR_FC = 8'h46;
  localparam logic [7:0] MSP_MB_SUB_TYPE  = 8'h08;

  // ************************************************************
  // type codes and engineering-unit full scale
  // ************************************************************
  localparam int         MSP_NUM_TYPES = 14;
  localparam logic [7:0] MSP_TC [MSP_NUM_TYPES] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
                                                    8'h1A, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
  localparam logic signed [15:0] MSP_FS_LO [MSP_NUM_TYPES] = '{16'sd4000, -16'sd10000, -16'sd5000,
    -16'sd10000, -16'sd5000, -16'sd15000, -16'sd20000, 16'sd0, 16'sd0, 16'sd4000, 16'sd0,
    -16'sd10000, 16'sd0, -16'sd5000};
  localparam logic signed [15:0] MSP_FS_HI [MSP_NUM_TYPES] = '{16'sd20000, 16'sd10000, 16'sd5000,
    16'sd10000, 16'sd5000, 16'sd15000, 16'sd20000, 16'sd20000, 16'sd20000, 16'sd20000, 16'sd10000,
    16'sd10000, 16'sd5000, 16'sd5000};
  localparam logic signed [15:0] MSP_UNDER = 16'sh8000;  // -32768
  localparam logic signed [15:0] MSP_OVER  = 16'sh7FFF;  // +32767

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ          = 100;
  localparam int HWD_STEP_MS      = 100;   // 0.1 s per timeout unit
  localparam int HWD_STEP_CYCLES  = HWD_STEP_MS * 1000 * CLK_MHZ;
  localparam int MWD_TIMEOUT_MS   = 1000;
  localparam int MWD_CYCLES       = MWD_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int MSP_DO_W         = 8;

endpackage

// ### testbench/msp_sup_monitor.sv
/*
  port checker for msp_supervisor, bound to every instance.
  assumes one clock domain with an async active-low reset.
*/
`timescale 1ns/10ps
module msp_sup_monitor
  import msp_pkg::*;
(
  input wire logic                    i_mclk,
  input wire logic                    i_reset_n,
  input wire logic                    i_clk_en,
  input wire msp_pkg::msp_cmd_req_t   i_cmd,
  input wire logic                    i_resp_done,
  input wire logic                    i_status_sent,
  input wire logic [7:0]              i_rd_type,
  input wire logic signed [15:0]      i_rd_raw,
  input wire logic                    i_rd_valid,
  input wire logic [7:0]              i_do_safe,
  input wire logic                    o_pwr_led,
  input wire logic                    o_init_mode,
  input wire logic                    o_cfg_wr,
  input wire logic                    o_cal_reload,
  input wire logic                    o_reset_status,
  input wire logic                    o_hwd_expired,
  input wire logic                    o_mod_reset,
  input wire logic signed [15:0]      o_eu_value,
  input wire logic                    o_eu_valid,
  input wire logic                    o_type_wr,
  input wire logic [7:0]              o_type_val,
  input wire logic [7:0]              o_dout
);
  // ************************************************************
  // port relations
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // taken command and type-08 reading; only type 08 is watched to keep this small
  logic tk;
  logic t8;
  assign tk = i_clk_en && i_cmd.valid;
  assign t8 = i_clk_en && i_rd_valid && (i_rd_type == 8'h08);
  a_led_cmd_off: assert property (tk |=> !o_pwr_led) else $error("led on after command");
  a_led_done_on: assert property (i_clk_en && i_resp_done && !i_cmd.valid |=> o_pwr_led)
    else $error("led off after reply");
  a_eu_under: assert property (t8 && i_rd_raw < -16'sd10000 |=> o_eu_valid && o_eu_value == MSP_UNDER)
    else $error("no under sentinel");
  a_eu_over: assert property (t8 && i_rd_raw > 16'sd10000 |=> o_eu_valid && o_eu_value == MSP_OVER)
    else $error("no over sentinel");
  a_eu_scaled: assert property (t8 && i_rd_raw >= -16'sd10000 && i_rd_raw <= 16'sd10000
    |=> o_eu_value == $past(i_rd_raw)) else $error("in-range value altered");
  a_cal_strobe: assert property (tk && i_cmd.cmd == MSP_CMD_FACTORY_CAL |=> o_cal_reload)
    else $error("no reload strobe");
  a_type_write: assert property (tk && i_cmd.cmd == MSP_CMD_MB_VENDOR && i_cmd.func_code == 8'h46
    && i_cmd.sub_func == 8'h08 |=> o_type_wr && o_type_val == $past(i_cmd.arg_type)) else $error("no type write");
  a_proto_refuse: assert property (tk && i_cmd.cmd == MSP_CMD_PROTO_SELECT && !o_init_mode |=> !o_cfg_wr)
    else $error("protocol change outside init");
  a_flag_clear: assert property (i_clk_en && i_status_sent && !o_mod_reset |=> !o_reset_status)
    else $error("flag not cleared");
  a_wdog_flag: assert property (o_mod_reset |=> o_reset_status) else $error("flag not set");
  a_safe_hold: assert property (o_hwd_expired [*2] |-> o_dout == i_do_safe)
    else $error("outputs not safe");
  c_led: cover property (tk ##1 !o_pwr_led);
  c_wdog: cover property (o_mod_reset);
  c_expire: cover property (o_hwd_expired [*2]);
endmodule

bind msp_supervisor msp_sup_monitor u_mon (.i_mclk, .i_reset_n, .i_clk_en, .i_cmd, .i_resp_done, .i_status_sent,
  .i_rd_type, .i_rd_raw, .i_rd_valid, .i_do_safe, .o_pwr_led, .o_init_mode, .o_cfg_wr, .o_cal_reload,
  .o_reset_status, .o_hwd_expired, .o_mod_reset, .o_eu_value, .o_eu_valid, .o_type_wr, .o_type_val, .o_dout);

// ### testbench/msp_host_model.sv
/*
  host model: issues one-cycle commands, then ends its reply after dly cycles.
  assumes the caller starts a send off the clock edge.
*/
`timescale 1ns/10ps
module msp_host_model
  import msp_pkg::*;
(
  input  wire logic     i_mclk,
  output msp_cmd_req_t  o_cmd,
  output logic          o_resp_done
);
  // ************************************************************
  // command and reply pacing
  // ************************************************************
  int dly = 1;
  int cnt = -1;
  initial o_cmd = '0;
  initial o_resp_done = 1'b0;
  // released fields show the inverse so stale values are never trusted
  task automatic send(input msp_cmd_req_t c);
    msp_cmd_req_t t;
    t = ~c;
    t.valid = 1'b0;
    c.valid = 1'b1;
    @(posedge i_mclk);
    o_cmd <= c;
    @(posedge i_mclk);
    o_cmd <= t;
  endtask
  // slow or prompt reply end, set by dly
  always @(posedge i_mclk)
  begin
    o_resp_done <= (cnt == 0);
    if (o_cmd.valid)
      cnt <= dly;
    else if (cnt >= 0)
      cnt <= cnt - 1;
  end
endmodule

// ### testbench/msp_supervisor_tb.sv
/*
  self-checking bench for msp_supervisor.
  assumes short watchdog parameters and a free-running kick process.
*/
`timescale 1ns/10ps
module msp_supervisor_tb;
  import msp_pkg::*;
  localparam msp_cfg_t   ST = '{8'h21, 6'h08, 1'b1, 1'b1};
  localparam logic [7:0] SF = 8'hA5;
  localparam logic [7:0] PO = 8'h0F;
  logic i_mclk = 1'b0, i_reset_n = 1'b0, i_init_strap = 1'b0, i_status_sent = 1'b0, i_mb_status_read = 1'b0;
  logic i_kick = 1'b0, i_rd_valid = 1'b0, i_do_wr = 1'b0, kick_en = 1'b1, i_pwron_use_safe = 1'b0;
  logic [7:0] i_hwd_timeout = 8'h00, i_rd_type = 8'h00, i_do_cmd = 8'h00, kc = 8'h00;
  logic signed [15:0] i_rd_raw = 16'sh0000;
  msp_cmd_req_t i_cmd, c;
  msp_cfg_t o_work_cfg, o_cfg_wr_data;
  logic i_resp_done, o_pwr_led, o_init_mode, o_cfg_wr, o_readback_stored, o_type_wr, o_cal_reload;
  logic o_reset_status, o_hwd_expired, o_mod_reset, o_eu_valid;
  logic [2:0] o_type_chan;
  logic [7:0] o_type_val, o_dout;
  logic signed [15:0] o_eu_value;
  int err_count = 0, compares = 0, n;
  initial forever #5 i_mclk = ~i_mclk;
  // firmware kicks every 8 cycles, well inside the short watchdog limit
  always @(posedge i_mclk)
  begin
    kc <= kc + 8'h01;
    i_kick <= kick_en && (kc[2:0] == 3'h0);
  end
  msp_host_model u_host (.i_mclk(i_mclk), .o_cmd(i_cmd), .o_resp_done(i_resp_done));
  msp_supervisor #(.HWD_STEP(4), .MWD_LIMIT(20)) DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_clk_en(1'b1),
    .i_init_strap(i_init_strap), .i_cmd(i_cmd), .i_resp_done(i_resp_done), .i_status_sent(i_status_sent),
    .i_mb_status_read(i_mb_status_read), .i_kick(i_kick), .i_stored_cfg(ST), .i_hwd_timeout(i_hwd_timeout),
    .i_rd_type(i_rd_type), .i_rd_raw(i_rd_raw), .i_rd_valid(i_rd_valid), .i_do_cmd(i_do_cmd), .i_do_wr(i_do_wr),
    .i_do_safe(SF), .i_do_pwron(PO), .i_pwron_use_safe(i_pwron_use_safe), .o_pwr_led(o_pwr_led),
    .o_work_cfg(o_work_cfg),
    .o_init_mode(o_init_mode), .o_cfg_wr(o_cfg_wr), .o_cfg_wr_data(o_cfg_wr_data),
    .o_readback_stored(o_readback_stored), .o_type_wr(o_type_wr), .o_type_chan(o_type_chan),
    .o_type_val(o_type_val), .o_cal_reload(o_cal_reload), .o_reset_status(o_reset_status),
    .o_hwd_expired(o_hwd_expired), .o_mod_reset(o_mod_reset), .o_eu_value(o_eu_value),
    .o_eu_valid(o_eu_valid), .o_dout(o_dout));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_b(input string s, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic chk_v(input string s, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tmo(input int lim);
    if (n >= lim)
    begin
      err_count++;
      $display("Error wait exp done got timeout");
      give_verdict;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic snd(input msp_cmd_t k);
    c.cmd = k;
    u_host.send(c);
    #1;
  endtask
  task automatic eu(input logic [7:0] t, input logic signed [15:0] r, input logic [15:0] e);
    @(posedge i_mclk);
    i_rd_type <= t;
    i_rd_raw <= r;
    i_rd_valid <= 1'b1;
    @(posedge i_mclk);
    i_rd_valid <= 1'b0;
    #1;
    chk_b("eu_valid", 1'b1, o_eu_valid);
    chk_v("eu_value", e, o_eu_value);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    chk_b("led", 1'b1, o_pwr_led);
    chk_b("flag", 1'b1, o_reset_status);
    chk_v("cfg", ST, o_work_cfg);
    chk_v("dout", {8'h00, PO}, {8'h00, o_dout});
    $display("test reset done");
  endtask
  task automatic t_led;
    c = '0;
    u_host.dly = 3;
    snd(MSP_CMD_FACTORY_CAL);
    chk_b("cal", 1'b1, o_cal_reload);
    chk_b("led_off", 1'b0, o_pwr_led);
    cyc(3);
    chk_b("led_busy", 1'b0, o_pwr_led);
    for (n = 0; n < 10 && o_pwr_led !== 1'b1; n++) cyc(1);
    tmo(10);
    chk_b("led_on", 1'b1, o_pwr_led);
    $display("test led done");
  endtask
  task automatic t_eu;
    for (int i = 0; i < MSP_NUM_TYPES; i++)
    begin
      eu(MSP_TC[i], MSP_FS_LO[i] - 16'sd1, MSP_UNDER);
      eu(MSP_TC[i], MSP_FS_HI[i] + 16'sd1, MSP_OVER);
      eu(MSP_TC[i], MSP_FS_LO[i], MSP_FS_LO[i]);
    end
    $display("test eu done");
  endtask
  task automatic t_cmds;
    c.func_code = MSP_MB_VENDOR_FC;
    c.sub_func = MSP_MB_SUB_TYPE;
    c.chan = 3'h5;
    c.arg_type = 8'h0D;
    snd(MSP_CMD_MB_VENDOR);
    chk_b("type_wr", 1'b1, o_type_wr);
    chk_v("type", 16'h050D, {5'h00, o_type_chan, o_type_val});
    c.arg_baud = 6'h07;
    c.arg_proto = 1'b1;
    snd(MSP_CMD_PROTO_SELECT);
    chk_b("proto_wr", 1'b0, o_cfg_wr);
    snd(MSP_CMD_SET_CONFIG);
    chk_v("cfg_keep", {9'h000, ST.baud, ST.cks_en}, {9'h000, o_cfg_wr_data.baud, o_cfg_wr_data.cks_en});
    $display("test commands done");
  endtask
  task automatic t_status;
    @(posedge i_mclk);
    i_status_sent <= 1'b1;
    @(posedge i_mclk);
    i_status_sent <= 1'b0;
    i_do_wr <= 1'b1;
    i_do_cmd <= 8'h3C;
    @(posedge i_mclk);
    i_do_wr <= 1'b0;
    kick_en <= 1'b0;  // non-blocking so the kick process sees it without a race
    #1;
    chk_b("flag_clr", 1'b0, o_reset_status);
    for (n = 0; n < 40 && o_mod_reset !== 1'b1; n++) cyc(1);
    tmo(40);
    kick_en = 1'b1;
    cyc(1);
    chk_b("flag_wd", 1'b1, o_reset_status);
    chk_v("dout_wd", {8'h00, PO}, {8'h00, o_dout});
    repeat (2)
    begin
      @(posedge i_mclk);
      i_mb_status_read <= 1'b1;
      @(posedge i_mclk);
      i_mb_status_read <= 1'b0;
      #1;
      chk_b("mb_flag", 1'b0, o_reset_status);
    end
    $display("test status done");
  endtask
  task automatic t_hwd;
    chk_b("hwd_off", 1'b0, o_hwd_expired);
    @(posedge i_mclk);
    i_hwd_timeout <= 8'h02;
    repeat (3)
    begin
      cyc(4);
      snd(MSP_CMD_OTHER);
    end
    chk_b("hwd_kept", 1'b0, o_hwd_expired);
    for (n = 0; n < 20 && o_hwd_expired !== 1'b1; n++) cyc(1);
    tmo(20);
    // two units of four cycles after the last command, plus the output register
    chk_v("hwd_time", 16'h0009, 16'(n));
    cyc(2);
    chk_v("dout_safe", {8'h00, SF}, {8'h00, o_dout});
    $display("test host watchdog done");
  endtask
  task automatic t_init;
    @(posedge i_mclk);
    i_reset_n <= 1'b0;
    i_pwron_use_safe <= 1'b1;
    i_init_strap <= 1'b1;
    i_hwd_timeout <= 8'h00;
    cyc(2);
    @(posedge i_mclk);
    i_reset_n <= 1'b1;
    cyc(3);
    chk_v("init_cfg", {MSP_INIT_ADDR, MSP_BAUD_9600, MSP_INIT_CKS, MSP_PROTO_ASCII}, o_work_cfg);
    chk_b("flag_po", 1'b1, o_reset_status);
    chk_v("dout_po", {8'h00, SF}, {8'h00, o_dout});
    @(posedge i_mclk);
    i_init_strap <= 1'b0;
    cyc(3);
    chk_b("init_held", 1'b1, o_init_mode);
    snd(MSP_CMD_CFG_READBACK);
    chk_b("readback", 1'b1, o_readback_stored);
    chk_b("no_store", 1'b0, o_cfg_wr);
    c.arg_cks = 1'b1;
    snd(MSP_CMD_SET_CONFIG);
    chk_v("cfg_new", 16'h000F, {9'h000, o_cfg_wr_data.baud, o_cfg_wr_data.cks_en});
    snd(MSP_CMD_PROTO_SELECT);
    chk_b("proto_ok", 1'b1, o_cfg_wr);
    chk_b("proto_val", 1'b1, o_cfg_wr_data.proto_mb);
    $display("test init done");
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    cyc(3);
    t_reset;
    t_led;
    t_eu;
    t_cmds;
    t_status;
    t_hwd;
    t_init;
    give_verdict;
  end
endmodule
